// ---- rtl/mviu_top.sv ----
`timescale 1ns/1ps
`include "mviu_defs.svh"
module mviu_top (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Register port
    input wire mviu_pkg::mviu_reg_req_t i_reg,
    output logic [7:0] o_rdata,
    // Sources
    input wire logic i_ext_irq_pin_a,
    input wire logic i_ext_irq_pin_b,
    input wire logic [1:0] i_edge_sel_a,
    input wire logic [1:0] i_edge_sel_b,
    input wire logic i_timer_overflow,
    input wire logic i_timebase_tick,
    input wire logic i_clock_tick,
    // Core sequencer
    input wire logic i_phase_two_pulse,
    input wire logic [10:0] i_pc,
    input wire mviu_pkg::mviu_seq_t i_seq,
    output mviu_pkg::mviu_ack_t o_ack,
    output logic [10:0] o_return_pc,
    output logic o_stack_full,
    output logic o_wake
);
    import mviu_pkg::*;

    // ------------------------------------------------------------
    // Control registers and edge detection
    // ------------------------------------------------------------
    logic global_irq_enable_q;
    logic ext0_irq_enable_q;
    logic ext1_irq_enable_q;
    logic timer_irq_enable_q;
    logic timebase_irq_enable_q;
    logic clock_tick_irq_enable_q;
    logic [4:0] flag_q;
    logic [4:0] flag_d;
    logic [4:0] enable;
    logic [4:0] event_set;
    logic [4:0] service;
    logic pin_a_q;
    logic pin_b_q;
    logic edge_a;
    logic edge_b;
    logic [2:0] sp_q;
    logic [10:0] stack_q [0:3];
    logic [1:0] top_idx;
    logic wr_low;
    logic wr_high;
    logic ack;
    logic [10:0] vec;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
        end else begin
            pin_a_q <= i_ext_irq_pin_a;
            pin_b_q <= i_ext_irq_pin_b;
        end
    end

    function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
        logic r;
        r = 1'b0;
        case (sel)
            `MVIU_EDGE_FALL: r = prev & ~cur;
            `MVIU_EDGE_RISE: r = ~prev & cur;
            `MVIU_EDGE_BOTH: r = prev ^ cur;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    assign edge_a = edge_hit(pin_a_q, i_ext_irq_pin_a, i_edge_sel_a);
    assign edge_b = edge_hit(pin_b_q, i_ext_irq_pin_b, i_edge_sel_b);
    assign event_set = {i_clock_tick, i_timebase_tick, i_timer_overflow, edge_b, edge_a};
    assign enable = {clock_tick_irq_enable_q, timebase_irq_enable_q, timer_irq_enable_q,
                     ext1_irq_enable_q, ext0_irq_enable_q};

    assign wr_low = i_reg.wr && (i_reg.addr == `MVIU_ADDR_CTRL_LOW);
    assign wr_high = i_reg.wr && (i_reg.addr == `MVIU_ADDR_CTRL_HIGH);

    // ------------------------------------------------------------
    // Arbitration: serviced only on phase-two pulse
    // ------------------------------------------------------------
    // Fixed priority, lowest index wins; sampling on the pulse makes all
    // flags raised since the previous pulse compete together.
    always_comb begin
        service = 5'h00;
        vec = `MVIU_VEC_EXT0;
        if (i_phase_two_pulse && global_irq_enable_q && (sp_q != `MVIU_STACK_DEPTH)) begin
            if (flag_q[0] && enable[0]) begin
                service = 5'h01;
                vec = `MVIU_VEC_EXT0;
            end else if (flag_q[1] && enable[1]) begin
                service = 5'h02;
                vec = `MVIU_VEC_EXT1;
            end else if (flag_q[2] && enable[2]) begin
                service = 5'h04;
                vec = `MVIU_VEC_TIMER;
            end else if (flag_q[3] && enable[3]) begin
                service = 5'h08;
                vec = `MVIU_VEC_TB;
            end else if (flag_q[4] && enable[4]) begin
                service = 5'h10;
                vec = `MVIU_VEC_TICK;
            end
        end
    end
    assign ack = |service;

    // ------------------------------------------------------------
    // Request flags
    // ------------------------------------------------------------
    always_comb begin
        flag_d = flag_q;
        if (wr_low) begin
            flag_d[0] = i_reg.wdata[`MVIU_BIT_EXT0_FLAG];
            flag_d[1] = i_reg.wdata[`MVIU_BIT_EXT1_FLAG];
            flag_d[2] = i_reg.wdata[`MVIU_BIT_TIMER_FLAG];
        end
        if (wr_high) begin
            flag_d[3] = i_reg.wdata[`MVIU_BIT_TB_FLAG];
            flag_d[4] = i_reg.wdata[`MVIU_BIT_TICK_FLAG];
        end
        flag_d = (flag_d & ~service) | event_set;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flag_q <= 5'h00;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ------------------------------------------------------------
    // Enable bits
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            global_irq_enable_q <= 1'b0;
            ext0_irq_enable_q <= 1'b0;
            ext1_irq_enable_q <= 1'b0;
            timer_irq_enable_q <= 1'b0;
        end else begin
            if (wr_low) begin
                ext0_irq_enable_q <= i_reg.wdata[`MVIU_BIT_EXT0_EN];
                ext1_irq_enable_q <= i_reg.wdata[`MVIU_BIT_EXT1_EN];
                timer_irq_enable_q <= i_reg.wdata[`MVIU_BIT_TIMER_EN];
            end
            // Acknowledge outranks a same-cycle software write of global
            if (ack) begin
                global_irq_enable_q <= 1'b0;
            end else if (i_seq.irq_return) begin
                global_irq_enable_q <= 1'b1;
            end else if (wr_low) begin
                global_irq_enable_q <= i_reg.wdata[`MVIU_BIT_GLOBAL];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            timebase_irq_enable_q <= 1'b0;
            clock_tick_irq_enable_q <= 1'b0;
        end else if (wr_high) begin
            timebase_irq_enable_q <= i_reg.wdata[`MVIU_BIT_TB_EN];
            clock_tick_irq_enable_q <= i_reg.wdata[`MVIU_BIT_TICK_EN];
        end
    end

    // ------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------
    // Pointer never leaves the block; a call on a full stack drops the
    // oldest entry by shifting the rest down and writing the top slot.
    assign top_idx = sp_q[1:0] - 2'h1;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sp_q <= `MVIU_SP_ZERO;
        end else if (ack || i_seq.call) begin
            if (sp_q != `MVIU_STACK_DEPTH) begin
                sp_q <= sp_q + `MVIU_SP_ONE;
            end
        end else if ((i_seq.irq_return || i_seq.plain_return) && (sp_q != `MVIU_SP_ZERO)) begin
            sp_q <= sp_q - `MVIU_SP_ONE;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (ack || i_seq.call) begin
            if (sp_q == `MVIU_STACK_DEPTH) begin
                stack_q[0] <= stack_q[1];
                stack_q[1] <= stack_q[2];
                stack_q[2] <= stack_q[3];
                stack_q[3] <= i_pc;
            end else begin
                stack_q[sp_q[1:0]] <= i_pc;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ack <= '0;
            o_return_pc <= 11'h000;
        end else begin
            o_ack.ack <= ack;
            o_ack.vector <= vec;
            o_return_pc <= (sp_q == `MVIU_SP_ZERO) ? 11'h000 : stack_q[top_idx];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else if (i_reg.rd && i_reg.addr == `MVIU_ADDR_CTRL_LOW) begin
            o_rdata <= {1'b0, flag_q[2], flag_q[1], flag_q[0], timer_irq_enable_q,
                        ext1_irq_enable_q, ext0_irq_enable_q, global_irq_enable_q};
        end else if (i_reg.rd && i_reg.addr == `MVIU_ADDR_CTRL_HIGH) begin
            o_rdata <= {2'b00, flag_q[4], flag_q[3], 2'b00,
                        clock_tick_irq_enable_q, timebase_irq_enable_q};
        end else begin
            o_rdata <= 8'h00;
        end
    end

    assign o_stack_full = (sp_q == `MVIU_STACK_DEPTH);
    assign o_wake = |flag_q;
endmodule // mviu_top

// ---- rtl/mviu_defs.svh ----
// Function
// - Accept five sources: two external pins, timer, time base, clock tick.
// - Servicing clears global enable; later requests still set their flags.
// - No acknowledge while return stack full; wait for a return to pop.
// - Acknowledge pushes only program counter, then branches to the vector.
// - Chosen edge on external pin a or b sets flag bit 4 or 5.
// - Enabled external request branches to 04H or 08H, clearing flag and global enable.
// - Timer overflow sets bit 6; service branches to 0CH, clears flag and global.
// - Time base sets high bit 4; service branches to 10H, clears flag and global.
// - Clock tick sets high bit 5; service branches to 14H, clears flag and global.
// - In service, acknowledges wait for interrupt return or software re-enable.
// - Interrupt return sets global enable; plain return leaves it alone.
// - Requests between two phase-two pulses are served on the latter pulse.
// - Simultaneous requests served ext a, ext b, timer, time base, clock tick.
// - Low register: global bit 0, ext enables bits 1-2, timer bit 3, bit 7 zero.
// - High register: time base enable bit 0, tick enable bit 1; 2,3,6,7 zero.
// - Flags stay set until serviced or cleared; enables only block servicing.
// - Any of the five sources wakes the device from power-down.
// - Return stack holds four levels, pointer hidden from software.
`ifndef MVIU_DEFS_SVH
`define MVIU_DEFS_SVH

`define MVIU_ADDR_CTRL_LOW 8'h0b
`define MVIU_ADDR_CTRL_HIGH 8'h1e
`define MVIU_CTRL_RESET 8'h00
`define MVIU_BIT_GLOBAL 0
`define MVIU_BIT_EXT0_EN 1
`define MVIU_BIT_EXT1_EN 2
`define MVIU_BIT_TIMER_EN 3
`define MVIU_BIT_EXT0_FLAG 4
`define MVIU_BIT_EXT1_FLAG 5
`define MVIU_BIT_TIMER_FLAG 6
`define MVIU_BIT_TB_EN 0
`define MVIU_BIT_TICK_EN 1
`define MVIU_BIT_TB_FLAG 4
`define MVIU_BIT_TICK_FLAG 5
`define MVIU_VEC_EXT0 11'h004
`define MVIU_VEC_EXT1 11'h008
`define MVIU_VEC_TIMER 11'h00c
`define MVIU_VEC_TB 11'h010
`define MVIU_VEC_TICK 11'h014
`define MVIU_STACK_DEPTH 3'h4
`define MVIU_SP_ZERO 3'h0
`define MVIU_SP_ONE 3'h1
`define MVIU_EDGE_FALL 2'h0
`define MVIU_EDGE_RISE 2'h1
`define MVIU_EDGE_BOTH 2'h2

`endif

// ---- rtl/mviu_pkg.sv ----
package mviu_pkg;
    typedef enum logic [1:0] {
        MVIU_SRC_EXT0,
        MVIU_SRC_EXT1,
        MVIU_SRC_TIMER,
        MVIU_SRC_TB
    } mviu_unused_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mviu_reg_req_t;

    typedef struct packed {
        logic call;
        logic irq_return;
        logic plain_return;
    } mviu_seq_t;

    typedef struct packed {
        logic ack;
        logic [10:0] vector;
    } mviu_ack_t;
endpackage

// ---- dv/mviu_top_asserts.sv ----
`timescale 1ns/1ps
module mviu_top_asserts (
    // Watched ports
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire mviu_pkg::mviu_reg_req_t i_reg,
    input wire logic [7:0] o_rdata,
    input wire logic i_timer_overflow,
    input wire logic i_phase_two_pulse,
    input wire logic [10:0] i_pc,
    input wire mviu_pkg::mviu_ack_t o_ack,
    input wire logic [10:0] o_return_pc,
    input wire logic o_stack_full,
    input wire logic o_wake
);
    import mviu_pkg::*;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    AST_ACK_ON_PULSE: assert property (o_ack.ack |-> $past(i_phase_two_pulse))
        else $error("ack without phase pulse");
    AST_NO_ACK_FULL: assert property (o_ack.ack |-> !$past(o_stack_full))
        else $error("ack while stack full");
    AST_VECTOR: assert property (o_ack.ack |-> o_ack.vector inside {11'h004, 11'h008, 11'h00c, 11'h010, 11'h014})
        else $error("bad vector");
    AST_ONE_ACK: assert property (o_ack.ack |=> !o_ack.ack)
        else $error("ack twice");
    // Stack top is registered again, so the pushed value shows one cycle after the ack
    AST_PUSH_PC: assert property (o_ack.ack |=> o_return_pc == $past(i_pc, 2))
        else $error("pc not pushed");
    AST_RDATA_IDLE: assert property (!$past(i_reg.rd) |-> o_rdata == 8'h00)
        else $error("read data outside read");
    AST_LOW_TOP: assert property ($past(i_reg.rd) && $past(i_reg.addr) == 8'h0b |-> !o_rdata[7])
        else $error("low bit 7 set");
    AST_HIGH_SPARE: assert property ($past(i_reg.rd) && $past(i_reg.addr) == 8'h1e |-> (o_rdata & 8'hcc) == 8'h00)
        else $error("high spare bits set");
    AST_WAKE: assert property (i_timer_overflow |=> o_wake)
        else $error("no wake");
    cover property (o_ack.ack && o_ack.vector == 11'h004);
    cover property (o_stack_full ##[1:40] o_ack.ack);
    cover property (i_reg.rd ##1 o_rdata != 8'h00);
endmodule // mviu_top_asserts
bind mviu_top mviu_top_asserts u_asserts (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_reg(i_reg),
    .o_rdata(o_rdata), .i_timer_overflow(i_timer_overflow), .i_phase_two_pulse(i_phase_two_pulse),
    .i_pc(i_pc), .o_ack(o_ack), .o_return_pc(o_return_pc), .o_stack_full(o_stack_full), .o_wake(o_wake));

// ---- dv/mviu_core_model.sv ----
`timescale 1ns/1ps
module mviu_core_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Bench commands
    input wire mviu_pkg::mviu_seq_t i_cmd,
    // Sequencer side
    output logic o_phase_two_pulse,
    output logic [10:0] o_pc,
    output mviu_pkg::mviu_seq_t o_seq
);
    import mviu_pkg::*;
    logic [1:0] phase_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_q <= 2'h0;
            o_pc <= 11'h000;
        end else begin
            phase_q <= phase_q + 2'h1;
            o_pc <= o_pc + 11'h001;
        end
    end
    // One machine cycle is four clocks
    assign o_phase_two_pulse = (phase_q == 2'h3);
    // Calls only issued while no flag is pending, so never beside an ack
    assign o_seq = i_cmd;
endmodule // mviu_core_model

// ---- dv/mviu_top_tb.sv ----
`timescale 1ns/1ps
module mviu_top_tb;
    import mviu_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    mviu_reg_req_t i_reg = '0;
    logic pin_a = 1'b1;
    logic pin_b = 1'b0;
    logic tmr = 1'b0;
    logic tbase = 1'b0;
    logic tick = 1'b0;
    mviu_seq_t cmd = '0;
    logic pulse;
    logic [10:0] pc;
    mviu_seq_t seq;
    mviu_ack_t ack;
    logic [7:0] rdata;
    logic full;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    int acks = 0;
    always #25 i_clk_sys = ~i_clk_sys;
    mviu_core_model u_core (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_cmd(cmd),
        .o_phase_two_pulse(pulse), .o_pc(pc), .o_seq(seq));
    mviu_top DUT (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_reg(i_reg), .o_rdata(rdata),
        .i_ext_irq_pin_a(pin_a), .i_ext_irq_pin_b(pin_b), .i_edge_sel_a(2'h0), .i_edge_sel_b(2'h1),
        .i_timer_overflow(tmr), .i_timebase_tick(tbase), .i_clock_tick(tick), .i_phase_two_pulse(pulse),
        .i_pc(pc), .i_seq(seq), .o_ack(ack), .o_return_pc(), .o_stack_full(full), .o_wake());
    task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge i_clk_sys) begin
        cyc++;
        if (ack.ack === 1'b1)
            acks++;
        if (cyc == 4000) begin
            failures++;
            close_out();
        end
    end
    // Pins parked so a reset never looks like an edge
    task automatic do_reset();
        i_rst_b <= 1'b0;
        pin_a <= 1'b1;
        pin_b <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        @(posedge i_clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk_sys);
        i_reg.wr <= 1'b0;
        // One idle edge so the next request never reassigns in the same step
        @(posedge i_clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
        i_reg <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk_sys);
        i_reg.rd <= 1'b0;
        @(negedge i_clk_sys);
        chk(what, {3'h0, rdata}, {3'h0, e});
        @(posedge i_clk_sys);
    endtask
    task automatic sq(input logic [2:0] c);
        cmd <= c;
        @(posedge i_clk_sys);
        cmd <= '0;
        @(posedge i_clk_sys);
    endtask
    task automatic wait_ack(input logic [10:0] v, input string what);
        int n;
        n = 0;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (ack.ack !== 1'b1 && n < 40);
        chk(what, (ack.ack === 1'b1) ? ack.vector : 11'h7ff, v);
        @(posedge i_clk_sys);
    endtask
    task automatic t_regs();
        do_reset();
        rd(8'h0b, 8'h00, "low after reset");
        rd(8'h1e, 8'h00, "high after reset");
        wr(8'h1e, 8'hcf);
        rd(8'h1e, 8'h03, "high enables");
        wr(8'h0b, 8'h8f);
        rd(8'h0b, 8'h0f, "low enables");
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00, "unmapped");
        $display("test regs done");
    endtask
    task automatic t_priority();
        logic [7:0] lows [5] = '{8'h6e, 8'h4e, 8'h0e, 8'h0e, 8'h0e};
        do_reset();
        pin_a <= 1'b0;
        pin_b <= 1'b1;
        tmr <= 1'b1;
        tbase <= 1'b1;
        tick <= 1'b1;
        @(posedge i_clk_sys);
        tmr <= 1'b0;
        tbase <= 1'b0;
        tick <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        rd(8'h0b, 8'h70, "low flags");
        rd(8'h1e, 8'h30, "high flags");
        wr(8'h1e, 8'h33);
        wr(8'h0b, 8'h7f);
        for (int i = 0; i < 5; i++) begin
            wait_ack(11'(4 * (i + 1)), "vector");
            rd(8'h0b, lows[i], "low after service");
            sq(3'b010);
        end
        rd(8'h0b, 8'h0f, "global after return");
        $display("test priority done");
    endtask
    task automatic t_stack_full();
        int n;
        do_reset();
        wr(8'h0b, 8'h09);
        repeat (4) sq(3'b100);
        @(negedge i_clk_sys);
        chk("stack full", {10'h0, full}, 11'h001);
        @(posedge i_clk_sys);
        tmr <= 1'b1;
        @(posedge i_clk_sys);
        tmr <= 1'b0;
        n = acks;
        repeat (12) @(posedge i_clk_sys);
        chk("acks while full", 11'(acks - n), 11'h000);
        sq(3'b001);
        wait_ack(11'h00c, "timer vector");
        rd(8'h0b, 8'h08, "timer serviced");
        sq(3'b001);
        rd(8'h0b, 8'h08, "plain return");
        sq(3'b010);
        rd(8'h0b, 8'h09, "irq return");
        $display("test stack_full done");
    endtask
    task automatic t_nest();
        do_reset();
        wr(8'h0b, 8'h09);
        tmr <= 1'b1;
        @(posedge i_clk_sys);
        tmr <= 1'b0;
        wait_ack(11'h00c, "outer timer");
        rd(8'h0b, 8'h08, "global cleared in routine");
        wr(8'h0b, 8'h09);
        tmr <= 1'b1;
        @(posedge i_clk_sys);
        tmr <= 1'b0;
        wait_ack(11'h00c, "nested timer");
        $display("test nest done");
    endtask
    initial begin
        t_regs();
        t_priority();
        t_stack_full();
        t_nest();
        close_out();
    end
endmodule // mviu_top_tb
